// file: uac_defs.svh
// What this block does
// - when ready to enumerate, weakly pull D+ high to announce full speed 12 Mbit/s.
// - a setting selects internal pull-up or external pull-up on a chosen pin; internal default.
// - self-powered: watch VBUS sense input and keep D+ pull-up off while VBUS absent.
// - the VBUS sense pin number is held in a configuration setting.
// - detach high puts both data lines in high impedance and removes the pull-up.
// - detach low restores the pull-up, then waits for the host to enumerate.
// - wake output is driven high only while detached, to ask the host to resume.
// - no in-band remote wakeup while detached; the wake output replaces it.
// - detach input and wake output pins are each chosen by their own setting.
// - reported maximum power comes from a configuration value, default 300 mA.
// - bus-powered: budget 100 mA until configured, then up to 500 mA.
// - accept host suspend; bus-powered suspend turns radio off, budget 2.5 mA.
// - external loads such as LEDs or amplifiers can be switched off for suspend.
// - with a USB 2.0 host both ends settle on full speed, 12 Mbit/s.
`ifndef UAC_DEFS_SVH
`define UAC_DEFS_SVH
`define UAC_ADDR_W        12
`define UAC_GPIO_N        16
`define UAC_PIN_W         4
`define UAC_OFF_CTRL      12'h000
`define UAC_OFF_PINSEL    12'h004
`define UAC_OFF_MAXPWR    12'h008
`define UAC_OFF_STATUS    12'h00c
`define UAC_OFF_WAKE      12'h010
`define UAC_CTRL_RST      8'h00
`define UAC_CTRL_READY    0
`define UAC_CTRL_SELFPWR  1
`define UAC_CTRL_EXTPU    2
`define UAC_CTRL_LOADS    3
`define UAC_CTRL_DETEN    4
`define UAC_CTRL_WAKEEN   5
`define UAC_PINSEL_RST    32'h03020100
`define UAC_PS_PULLUP     0
`define UAC_PS_VBUS       8
`define UAC_PS_DETACH     16
`define UAC_PS_WAKE       24
`define UAC_MAXPWR_RST    16'h012c
`define UAC_ST_WAKEPEND   5
`define UAC_FS_RATE_MBPS  12
`endif

// file: uac_host_model.sv
`timescale 1ns/1ps
module uac_host_model
(
  input  wire logic clk,
  input  wire logic dp_o,
  input  wire logic dp_oe,
  input  wire logic dm_o,
  input  wire logic dm_oe,
  input  wire logic pull_int,
  input  wire logic pull_ext,
  output logic      dp_i,
  output logic      dm_i,
  output logic      fs_seen
);
  // host pull-downs win on a released line unless a device pull-up holds D+
  assign dp_i = dp_oe ? dp_o : (pull_int | pull_ext);
  assign dm_i = dm_oe ? dm_o : 1'b0;
  // only an idle bus tells the host the speed, so traffic leaves the last verdict
  always_ff @(posedge clk)
    if (!dp_oe && !dm_oe)
      fs_seen <= pull_int | pull_ext;
endmodule

// file: uac_pkg.sv
package uac_pkg;
  // current budget the circuit must keep within
  typedef enum logic [1:0]
  {
    UAC_PWR_UNCONF = 2'b00,
    UAC_PWR_CONF   = 2'b01,
    UAC_PWR_SUSP   = 2'b10
  } uac_pwr_t;
endpackage

// file: uac_top.sv
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "uac_defs.svh"
module uac_top
(
  input  wire logic                   CORE_CLK,
  input  wire logic                   RST,
  input  wire logic                   PSEL,
  input  wire logic                   PENABLE,
  input  wire logic                   PWRITE,
  input  wire logic [`UAC_ADDR_W-1:0] PADDR,
  input  wire logic [31:0]            PWDATA,
  output logic      [31:0]            PRDATA,
  output logic                        PREADY,
  output logic                        PSLVERR,
  input  wire logic [`UAC_GPIO_N-1:0] GPIO_IN,
  output logic      [`UAC_GPIO_N-1:0] GPIO_OUT,
  output logic      [`UAC_GPIO_N-1:0] GPIO_OE,
  input  wire logic                   USB_DPLUS_LINE_I,
  output logic                        USB_DPLUS_LINE_O,
  output logic                        USB_DPLUS_LINE_OE,
  input  wire logic                   USB_DMINUS_LINE_I,
  output logic                        USB_DMINUS_LINE_O,
  output logic                        USB_DMINUS_LINE_OE,
  output logic                        INT_PULLUP_EN,
  input  wire logic                   ENG_TX_EN,
  input  wire logic                   ENG_TX_DP,
  input  wire logic                   ENG_TX_DM,
  output logic                        ENG_RX_DP,
  output logic                        ENG_RX_DM,
  input  wire logic                   ENG_SUSPEND,
  input  wire logic                   ENG_CONFIGURED,
  input  wire logic                   ENG_RESUME_REQ,
  output logic                        ENG_INBAND_WAKE_OK,
  output logic                        ENG_ATTACHED,
  output logic                        FULL_SPEED,
  output logic      [15:0]            MAX_POWER_MA,
  output logic      [1:0]             CURRENT_BUDGET,
  output logic                        RADIO_EN,
  output logic                        EXT_LOAD_EN
);

  // configuration and state
  logic [7:0]             ctrl_r;
  logic [31:0]            pinsel_r;
  logic [15:0]            maxpwr_r;
  logic                   wake_sw_r;
  logic                   wake_pend_r;
  logic [`UAC_GPIO_N-1:0] gpio_meta_r;
  logic [`UAC_GPIO_N-1:0] gpio_sync_r;
  logic                   vbus_r;
  logic                   detach_r;
  logic                   pullup_r;
  logic                   dline_oe_r;
  logic                   dp_o_r;
  logic                   dm_o_r;
  logic                   rx_dp_r;
  logic                   rx_dm_r;
  logic                   wake_out_r;
  logic                   radio_r;
  logic                   loads_r;
  logic                   fs_r;
  logic [31:0]            prdata_r;
  logic                   pslverr_r;
  uac_pkg::uac_pwr_t      pwr_r;
  uac_pkg::uac_pwr_t      pwr_nxt;

  // decoded fields
  logic [`UAC_PIN_W-1:0]  pu_pin;
  logic [`UAC_PIN_W-1:0]  vbus_pin;
  logic [`UAC_PIN_W-1:0]  det_pin;
  logic [`UAC_PIN_W-1:0]  wake_pin;
  logic                   self_pwr;
  logic                   ext_pu;
  logic                   pullup_nxt;
  logic                   detach_now;
  logic                   vbus_now;
  logic                   setup;
  logic                   wr_acc;
  logic                   mapped;
  logic                   wake_clr;
  logic [31:0]            status_word;
  logic [31:0]            rd_word;

  assign pu_pin   = pinsel_r[`UAC_PS_PULLUP +: `UAC_PIN_W];
  assign vbus_pin = pinsel_r[`UAC_PS_VBUS +: `UAC_PIN_W];
  assign det_pin  = pinsel_r[`UAC_PS_DETACH +: `UAC_PIN_W];
  assign wake_pin = pinsel_r[`UAC_PS_WAKE +: `UAC_PIN_W];
  assign self_pwr = ctrl_r[`UAC_CTRL_SELFPWR];
  assign ext_pu   = ctrl_r[`UAC_CTRL_EXTPU];

  // apb phases; slave always answers in the first access cycle
  assign setup  = PSEL & ~PENABLE;
  assign wr_acc = PSEL & PENABLE & PWRITE;
  assign PREADY = 1'b1;

  // software settings: control, pin selection, descriptor power, wake request;
  // the wake request level only has an effect while detached
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      ctrl_r    <= `UAC_CTRL_RST;
      pinsel_r  <= `UAC_PINSEL_RST;
      maxpwr_r  <= `UAC_MAXPWR_RST;
      wake_sw_r <= 1'b0;
    end
    else if (wr_acc)
    begin
      case (PADDR)
        `UAC_OFF_CTRL:   ctrl_r    <= {2'h0, PWDATA[5:0]};
        `UAC_OFF_PINSEL: pinsel_r  <= PWDATA & 32'h0f0f0f0f;
        `UAC_OFF_MAXPWR: maxpwr_r  <= PWDATA[15:0];
        `UAC_OFF_WAKE:   wake_sw_r <= PWDATA[0];
        default:         ;
      endcase
    end
  end

  // engine resume requests during detach are kept until cleared;
  // a new request in the clearing cycle wins so it is never lost
  assign wake_clr = wr_acc && PADDR == `UAC_OFF_STATUS && PWDATA[`UAC_ST_WAKEPEND];

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      wake_pend_r <= 1'b0;
    else if (ENG_RESUME_REQ && detach_r)
      wake_pend_r <= 1'b1;
    else if (wake_clr || !detach_r)
      wake_pend_r <= 1'b0;
  end

  // read data captured in setup so it comes straight from a flop
  assign status_word = {22'h0, pwr_r, 2'h0, wake_out_r, ENG_CONFIGURED,
                        (pwr_r == uac_pkg::UAC_PWR_SUSP), pullup_r, detach_r, vbus_r};

  always_comb
  begin
    rd_word = 32'h0;
    mapped  = 1'b1;
    case (PADDR)
      `UAC_OFF_CTRL:   rd_word = {24'h0, ctrl_r};
      `UAC_OFF_PINSEL: rd_word = pinsel_r;
      `UAC_OFF_MAXPWR: rd_word = {16'h0, maxpwr_r};
      `UAC_OFF_STATUS: rd_word = status_word | {26'h0, wake_pend_r, 5'h0};
      `UAC_OFF_WAKE:   rd_word = {31'h0, wake_sw_r};
      default:
      begin
        rd_word = 32'h0;
        mapped  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      prdata_r <= 32'h0;
    else if (setup)
      prdata_r <= PWRITE ? 32'h0 : rd_word;
  end

  // unmapped addresses answer with an error and read zero
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      pslverr_r <= 1'b0;
    else if (setup)
      pslverr_r <= ~mapped;
  end

  assign PRDATA  = prdata_r;
  assign PSLVERR = pslverr_r & PSEL & PENABLE;

  // detach only counts when its pin is enabled; vbus only in self-powered mode
  assign detach_now = ctrl_r[`UAC_CTRL_DETEN] & gpio_sync_r[det_pin];
  assign vbus_now   = ~self_pwr | gpio_sync_r[vbus_pin];

  // two-flop synchroniser on every pin; selection only reads the second stage
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      gpio_meta_r <= '0;
      gpio_sync_r <= '0;
      detach_r    <= 1'b0;
      vbus_r      <= 1'b0;
    end
    else
    begin
      gpio_meta_r <= GPIO_IN;
      gpio_sync_r <= gpio_meta_r;
      detach_r    <= detach_now;
      vbus_r      <= vbus_now;
    end
  end

  // pull-up only when ready, attached and, if self-powered, vbus present;
  // dropping detach brings it straight back and the host re-enumerates
  assign pullup_nxt = ctrl_r[`UAC_CTRL_READY] & ~detach_r & vbus_r;

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      pullup_r <= 1'b0;
    else
      pullup_r <= pullup_nxt;
  end

  // internal current source used unless the external source is chosen
  assign INT_PULLUP_EN = pullup_r & ~ext_pu;
  assign ENG_ATTACHED  = pullup_r;

  // data lines follow the engine but float while detached; the enable uses the
  // next pull-up state so a line is never driven after the pull-up has gone
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      dline_oe_r <= 1'b0;
      dp_o_r     <= 1'b0;
      dm_o_r     <= 1'b0;
      rx_dp_r    <= 1'b0;
      rx_dm_r    <= 1'b0;
    end
    else
    begin
      dline_oe_r <= ENG_TX_EN & pullup_nxt;
      dp_o_r     <= ENG_TX_DP;
      dm_o_r     <= ENG_TX_DM;
      rx_dp_r    <= detach_r ? 1'b1 : USB_DPLUS_LINE_I;
      rx_dm_r    <= detach_r ? 1'b0 : USB_DMINUS_LINE_I;
    end
  end

  assign USB_DPLUS_LINE_O   = dp_o_r;
  assign USB_DPLUS_LINE_OE  = dline_oe_r;
  assign USB_DMINUS_LINE_O  = dm_o_r;
  assign USB_DMINUS_LINE_OE = dline_oe_r;
  assign ENG_RX_DP          = rx_dp_r;
  assign ENG_RX_DM          = rx_dm_r;

  // in-band remote wakeup is not allowed over a disconnected cable
  assign ENG_INBAND_WAKE_OK = ~detach_r & pullup_r;

  // out-of-band wake, active high and only during detach
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      wake_out_r <= 1'b0;
    else
      wake_out_r <= detach_now & detach_r & (wake_sw_r | wake_pend_r);
  end

  // pin drivers: wake pin driven when enabled, external pull-up pin
  // floats when off so the resistor no longer sources D+
  genvar gi;
  generate
    for (gi = 0; gi < `UAC_GPIO_N; gi = gi + 1)
    begin : g_pin
      logic is_wake;
      logic is_pu;
      assign is_wake = ctrl_r[`UAC_CTRL_WAKEEN] && wake_pin == gi[`UAC_PIN_W-1:0];
      assign is_pu   = ext_pu && pu_pin == gi[`UAC_PIN_W-1:0] && !is_wake;
      always_ff @(posedge CORE_CLK)
      begin
        if (RST)
        begin
          GPIO_OUT[gi] <= 1'b0;
          GPIO_OE[gi]  <= 1'b0;
        end
        else if (is_wake)
        begin
          GPIO_OUT[gi] <= wake_out_r;
          GPIO_OE[gi]  <= 1'b1;
        end
        else if (is_pu)
        begin
          GPIO_OUT[gi] <= 1'b1;
          GPIO_OE[gi]  <= pullup_r;
        end
        else
        begin
          GPIO_OUT[gi] <= 1'b0;
          GPIO_OE[gi]  <= 1'b0;
        end
      end
    end
  endgenerate

  // power budget: losing the pull-up is an unplug and restarts at 100 mA
  always_comb
  begin
    pwr_nxt = pwr_r;
    if (!pullup_r)
      pwr_nxt = uac_pkg::UAC_PWR_UNCONF;
    else
    begin
      case (pwr_r)
        uac_pkg::UAC_PWR_UNCONF:
        begin
          if (ENG_SUSPEND)
            pwr_nxt = uac_pkg::UAC_PWR_SUSP;
          else if (ENG_CONFIGURED)
            pwr_nxt = uac_pkg::UAC_PWR_CONF;
        end
        uac_pkg::UAC_PWR_CONF:
        begin
          if (ENG_SUSPEND)
            pwr_nxt = uac_pkg::UAC_PWR_SUSP;
          else if (!ENG_CONFIGURED)
            pwr_nxt = uac_pkg::UAC_PWR_UNCONF;
        end
        uac_pkg::UAC_PWR_SUSP:
        begin
          if (!ENG_SUSPEND)
            pwr_nxt = ENG_CONFIGURED ? uac_pkg::UAC_PWR_CONF : uac_pkg::UAC_PWR_UNCONF;
        end
        default:
          pwr_nxt = uac_pkg::UAC_PWR_UNCONF;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      pwr_r <= uac_pkg::UAC_PWR_UNCONF;
    else
      pwr_r <= pwr_nxt;
  end

  assign CURRENT_BUDGET = pwr_r;

  // radio off in bus-powered suspend; self-powered may keep running
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      radio_r <= 1'b0;
    else
      radio_r <= self_pwr | (pwr_nxt != uac_pkg::UAC_PWR_SUSP);
  end

  // external loads follow software but always drop in suspend
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      loads_r <= 1'b0;
    else
      loads_r <= ctrl_r[`UAC_CTRL_LOADS] & (pwr_nxt != uac_pkg::UAC_PWR_SUSP);
  end

  assign RADIO_EN     = radio_r;
  assign EXT_LOAD_EN  = loads_r;
  assign MAX_POWER_MA = maxpwr_r;

  // port is full speed only; high speed chirp never attempted
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      fs_r <= 1'b0;
    else
      fs_r <= (`UAC_FS_RATE_MBPS == 12);
  end

  assign FULL_SPEED = fs_r;

endmodule

// file: uac_top_assertions.sv
`timescale 1ns/1ps
module uac_top_checker
(
  input wire logic        CORE_CLK,
  input wire logic        RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        USB_DPLUS_LINE_OE,
  input wire logic        USB_DMINUS_LINE_OE,
  input wire logic        INT_PULLUP_EN,
  input wire logic        ENG_SUSPEND,
  input wire logic        ENG_CONFIGURED,
  input wire logic        ENG_INBAND_WAKE_OK,
  input wire logic        ENG_ATTACHED,
  input wire logic        FULL_SPEED,
  input wire logic [15:0] MAX_POWER_MA,
  input wire logic [1:0]  CURRENT_BUDGET,
  input wire logic        EXT_LOAD_EN
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  property p_ready; PSEL && PENABLE |-> PREADY; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access cycle");
  property p_slverr; PSLVERR |-> PSEL && PENABLE; endproperty
  a_slverr: assert property (p_slverr) else $error("error outside access cycle");
  property p_lines; USB_DPLUS_LINE_OE || USB_DMINUS_LINE_OE |-> ENG_ATTACHED; endproperty
  a_lines: assert property (p_lines) else $error("data line driven while off the bus");
  property p_intpu; INT_PULLUP_EN |-> ENG_ATTACHED; endproperty
  a_intpu: assert property (p_intpu) else $error("pull-up without attach");
  property p_inband; ENG_INBAND_WAKE_OK |-> ENG_ATTACHED; endproperty
  a_inband: assert property (p_inband) else $error("in-band wake while detached");
  property p_fs; !RST |-> ##1 FULL_SPEED; endproperty
  a_fs: assert property (p_fs) else $error("full speed not announced");
  property p_unconf; !ENG_CONFIGURED && !ENG_SUSPEND |=> CURRENT_BUDGET == 2'b00; endproperty
  a_unconf: assert property (p_unconf) else $error("budget above 100 mA");
  property p_susp;
    ENG_SUSPEND && ENG_ATTACHED ##1 ENG_ATTACHED |-> CURRENT_BUDGET == uac_pkg::UAC_PWR_SUSP;
  endproperty
  a_susp: assert property (p_susp) else $error("suspend budget missing");
  property p_loads; EXT_LOAD_EN |-> CURRENT_BUDGET != uac_pkg::UAC_PWR_SUSP; endproperty
  a_loads: assert property (p_loads) else $error("loads on in suspend");
  // the first cycles after reset may still load the default value
  property p_maxpwr;
    $changed(MAX_POWER_MA) && !$past(RST) && !$past(RST, 2)
      |-> $past(PSEL && PENABLE && PWRITE && PADDR == 12'h008);
  endproperty
  a_maxpwr: assert property (p_maxpwr) else $error("max power moved unasked");
endmodule
bind uac_top uac_top_checker chk_u (.*);

// file: usb_attach_detach_control_bench.sv
`timescale 1ns/1ps
module usb_attach_detach_control_bench;
  logic        clk, rst = 1, psel = 0, pen = 0, pwr = 0, pready, pslverr, rerr;
  logic        dp_i, dp_o, dp_oe, dm_i, dm_o, dm_oe, int_pu, wake_ok, attached;
  logic        tx_en = 0, tx_dp = 0, tx_dm = 0, susp = 0, cfgd = 0, rsm = 0;
  logic        fs, radio, loads, fs_seen, rx_dp, rx_dm;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat, r, rnd;
  logic [15:0] gin = 0, gout, goe, maxpwr;
  logic [1:0]  budget;
  logic [3:0]  pu_pin = 0, vb_pin = 0, dt_pin = 0, wk_pin = 0;
  integer      seed = 66;
  int          err_count = 0, cmp_count = 0;

  uac_top dut_u
  (
    .CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .GPIO_IN(gin),
    .GPIO_OUT(gout), .GPIO_OE(goe), .USB_DPLUS_LINE_I(dp_i), .USB_DPLUS_LINE_O(dp_o),
    .USB_DPLUS_LINE_OE(dp_oe), .USB_DMINUS_LINE_I(dm_i), .USB_DMINUS_LINE_O(dm_o),
    .USB_DMINUS_LINE_OE(dm_oe), .INT_PULLUP_EN(int_pu), .ENG_TX_EN(tx_en),
    .ENG_TX_DP(tx_dp), .ENG_TX_DM(tx_dm), .ENG_RX_DP(rx_dp), .ENG_RX_DM(rx_dm),
    .ENG_SUSPEND(susp),
    .ENG_CONFIGURED(cfgd), .ENG_RESUME_REQ(rsm), .ENG_INBAND_WAKE_OK(wake_ok),
    .ENG_ATTACHED(attached), .FULL_SPEED(fs), .MAX_POWER_MA(maxpwr),
    .CURRENT_BUDGET(budget), .RADIO_EN(radio), .EXT_LOAD_EN(loads)
  );
  uac_host_model host_u
  (
    .clk(clk), .dp_o(dp_o), .dp_oe(dp_oe), .dm_o(dm_o), .dm_oe(dm_oe), .pull_int(int_pu),
    .pull_ext(goe[pu_pin] & gout[pu_pin]), .dp_i(dp_i), .dm_i(dm_i), .fs_seen(fs_seen)
  );

  // 20 MHz core clock
  initial
  begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  // sparse engine traffic keeps the line drivers busy but leaves idle gaps
  always @(posedge clk)
  begin
    rnd = $random(seed);
    tx_en <= rnd[2:0] == 3'h0;
    tx_dp <= rnd[3];
    tx_dm <= ~rnd[3];
  end

  function automatic logic [31:0] pinsel(input logic [3:0] p, v, d, w);
    return {4'h0, w, 4'h0, d, 4'h0, v, 4'h0, p};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; a fresh edge first so no signal is assigned twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
    chk(rerr, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(12'h000, 32'h0, 1'b0);
    rd(12'h004, 32'h03020100, 1'b0);
    rd(12'h008, 32'h12c, 1'b0);
    rd(12'h024, 32'h0, 1'b1);
    chk(fs, 1'b1);
    chk(maxpwr, 32'h12c);
    repeat (4)
    begin
      r = $random(seed);
      apb(1'b1, 12'h008, {16'h0, r[15:0]});
      rd(12'h008, {16'h0, r[15:0]}, 1'b0);
      chk(maxpwr, r[15:0]);
    end
    $display("test reset and max power done");
    r = $random(seed);
    pu_pin = {2'b00, r[1:0]};
    vb_pin = pu_pin + 4'h4;
    dt_pin = pu_pin + 4'h8;
    wk_pin = pu_pin + 4'hc;
    apb(1'b1, 12'h004, pinsel(pu_pin, vb_pin, dt_pin, wk_pin));
    rd(12'h004, pinsel(pu_pin, vb_pin, dt_pin, wk_pin), 1'b0);
    apb(1'b1, 12'h000, 32'h39);
    cyc(6);
    chk(int_pu, 1'b1);
    chk(fs_seen, 1'b1);
    chk(wake_ok, 1'b1);
    chk(budget, 2'b00);
    cfgd <= 1'b1;
    cyc(2);
    chk(budget, 2'b01);
    chk(loads, 1'b1);
    susp <= 1'b1;
    cyc(2);
    chk({budget, radio, loads}, 4'b1000);
    susp <= 1'b0;
    cyc(2);
    chk({budget, radio}, 3'b011);
    $display("test power states done");
    gin[dt_pin] <= 1'b1;
    cyc(2);
    chk(int_pu, 1'b1);
    cyc(4);
    chk({int_pu, dp_oe, dm_oe, wake_ok}, 4'h0);
    chk({rx_dp, rx_dm}, 2'b10);
    chk(goe[wk_pin] & gout[wk_pin], 1'b0);
    rsm <= 1'b1;
    @(posedge clk);
    rsm <= 1'b0;
    cyc(3);
    chk(goe[wk_pin] & gout[wk_pin], 1'b1);
    rd(12'h00c, 32'h33, 1'b0);
    apb(1'b1, 12'h00c, 32'h20);
    rd(12'h00c, 32'h13, 1'b0);
    chk(goe[wk_pin] & gout[wk_pin], 1'b0);
    apb(1'b1, 12'h010, 32'h1);
    cyc(3);
    chk(goe[wk_pin] & gout[wk_pin], 1'b1);
    gin[dt_pin] <= 1'b0;
    cyc(6);
    chk(int_pu, 1'b1);
    chk(goe[wk_pin] & gout[wk_pin], 1'b0);
    $display("test detach and wake done");
    cfgd <= 1'b0;
    apb(1'b1, 12'h000, 32'h07);
    cyc(6);
    chk(attached, 1'b0);
    chk(goe[pu_pin] & gout[pu_pin], 1'b0);
    gin[vb_pin] <= 1'b1;
    cyc(6);
    chk(goe[pu_pin] & gout[pu_pin], 1'b1);
    chk(int_pu, 1'b0);
    cyc(4);
    chk(fs_seen, 1'b1);
    $display("test self powered done");
    stop_test;
  end

  // a hang counts as a mismatch
  initial
  begin
    repeat (3000) @(posedge clk);
    err_count++;
    $display("ERROR %0t run too long", $time);
    stop_test;
  end
endmodule
